// [tb/ppa_pin_source.sv]
`timescale 1ns/100ps
module ppa_pin_source #(
  parameter int HIGH_CYCLES = 8,
  parameter int LOW_CYCLES = 12
) (
  input wire logic mclk,
  input wire logic enable,
  output logic pin
);
  // ****************************************
  // Square wave, low while disabled
  // ****************************************
  int count = 0;

  always @(posedge mclk) begin
    if (!enable) begin
      count <= 0;
      pin <= 1'b0;
    end else begin
      count <= (count == HIGH_CYCLES + LOW_CYCLES - 1) ? 0 : count + 1;
      pin <= (count < HIGH_CYCLES);
    end
  end
endmodule

// [tb/test_ppa_channel.sv]
`timescale 1ns/100ps
`include "ppa_map.svh"
`define CHK(act, exp) begin checks++; if ((act) !== (exp)) begin fails++; \
  $display("MISMATCH at %0t: got %0h expected %0h", $time, act, exp); end end
module test_ppa_channel;
  import ppa_pkg::*;
  localparam int HIGH_T = 8;
  localparam int LOW_T = 12;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] tc_one = 16'h0000;
  logic [15:0] tc_two = 16'h0000;
  logic pin_in;
  logic pin_out;
  logic pin_oe;
  logic irq;
  logic [15:0] link_out;
  logic [15:0] link_seen = 16'h0000;
  logic irq_seen = 1'b0;
  logic mon_clr = 1'b0;
  logic src_en = 1'b0;
  logic [31:0] rd;
  int fails = 0;
  int checks = 0;
  logic [5:0] offs [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C,
    6'h20, 6'h3C};
  logic [31:0] rvals [10] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h1,
    32'h10, 32'h0};

  ppa_channel #(.CHANNELS(16)) i_dut (.mclk(mclk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .timer_counter_one(tc_one), .timer_counter_two(tc_two), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq), .link_out(link_out));

  ppa_pin_source #(.HIGH_CYCLES(HIGH_T), .LOW_CYCLES(LOW_T)) i_src (.mclk(mclk),
    .enable(src_en), .pin(pin_in));

  always #2.5 mclk = ~mclk;

  // ****************************************
  // Time bases and output monitors
  // ****************************************
  always @(posedge mclk) begin
    tc_one <= tc_one + 16'h0001;
    tc_two <= tc_two + 16'h0003;
    link_seen <= mon_clr ? 16'h0000 : (link_seen | link_out);
    irq_seen <= mon_clr ? 1'b0 : (irq_seen | irq);
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Held until waitrequest is sampled low
  task automatic bus_cycle(input logic wr, input logic [5:0] addr, input logic [31:0] data);
    @(posedge mclk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic run_mode(input logic [1:0] seq, input logic [3:0] time_base_select_field,
    input logic [7:0] maxc, input logic en, input logic [23:0] sum, input logic [15:0] links);
    int n;
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, {23'h0, time_base_select_field, 3'h0, 2'h3});
    bus_cycle(1'b1, `PPA_OFF_HOST_SEQ, {30'h0, seq});
    bus_cycle(1'b1, `PPA_OFF_MAX_COUNT, {24'h0, maxc});
    bus_cycle(1'b1, `PPA_OFF_INT_EN, {31'h0, en});
    bus_cycle(1'b1, `PPA_OFF_HOST_SRV, {30'h0, `PPA_HSR_INIT});
    bus_cycle(1'b1, `PPA_OFF_INT_STAT, 32'h00000000);
    mon_clr <= 1'b1;
    @(posedge mclk);
    mon_clr <= 1'b0;
    n = 0;
    rd = 32'h00000000;
    while (rd[0] !== 1'b1 && n < 200) begin
      bus_cycle(1'b0, `PPA_OFF_INT_STAT, 32'h0);
      n++;
    end
    repeat (2) @(posedge mclk);
    `CHK(rd[0], 1'b1)
    `CHK(rd[1], 1'b0)
    bus_cycle(1'b0, `PPA_OFF_LAST_ACCUM, 32'h0);
    `CHK(rd[23:0], sum)
    `CHK(irq_seen, en)
    `CHK(irq, en)
    `CHK(link_seen, links)
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    stop_test;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK(pin_oe, 1'b0)
    `CHK(irq, 1'b0)
    for (int i = 0; i < 10; i++) begin
      bus_cycle(1'b0, offs[i], 32'h0);
      `CHK(rd, rvals[i])
    end
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h00000081);
    repeat (3) @(posedge mclk);
    `CHK(pin_oe, 1'b1)
    `CHK(pin_out, 1'b1)
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h00000082);
    repeat (3) @(posedge mclk);
    `CHK(pin_out, 1'b0)
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h00000091);
    bus_cycle(1'b0, `PPA_OFF_CHAN_CTL, 32'h0);
    `CHK(rd, 32'h00000081)
    `CHK(pin_out, 1'b1)
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h00000103);
    bus_cycle(1'b0, `PPA_OFF_CHAN_CTL, 32'h0);
    `CHK(rd, 32'h00000083)
    // Output match toggles the latch; pin follows it
    bus_cycle(1'b1, `PPA_OFF_PRIORITY, 32'h00000001);
    bus_cycle(1'b1, `PPA_OFF_MATCH_VALUE, {16'h0000, 16'(tc_one + 16'h0040)});
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h0000008C);
    repeat (2) @(posedge mclk);
    `CHK(pin_out, 1'b0)
    repeat (80) @(posedge mclk);
    `CHK(pin_out, 1'b1)
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h00000003);
    repeat (3) @(posedge mclk);
    `CHK(pin_oe, 1'b0)
    src_en <= 1'b1;
    bus_cycle(1'b1, `PPA_OFF_PRIORITY, 32'h00000001);
    // Link block starts at two, three channels
    bus_cycle(1'b1, `PPA_OFF_LINK_CFG, 32'h00000032);
    run_mode(2'h0, 4'h0, 8'h02, 1'b1, 24'(2 * (HIGH_T + LOW_T)), 16'h0000);
    run_mode(2'h2, 4'h3, 8'h02, 1'b0, 24'(2 * HIGH_T * 3), 16'h0000);
    run_mode(2'h1, 4'h0, 8'h01, 1'b1, 24'(HIGH_T + LOW_T), 16'h001C);
    run_mode(2'h3, 4'h1, 8'h03, 1'b1, 24'(3 * HIGH_T), 16'h001C);
    // Lower max count under a running count
    rd = 32'h00000000;
    for (int k = 0; k < 40 && rd[7:0] == 8'h00; k++) begin
      bus_cycle(1'b0, `PPA_OFF_PERIOD_COUNT, 32'h0);
    end
    bus_cycle(1'b1, `PPA_OFF_MAX_COUNT, 32'h00000000);
    bus_cycle(1'b0, `PPA_OFF_PERIOD_COUNT, 32'h0);
    `CHK(rd[7:0], 8'h00)
    // Rising edge detect sets the detect bit
    bus_cycle(1'b1, `PPA_OFF_CHAN_CTL, 32'h00000007);
    bus_cycle(1'b1, `PPA_OFF_INT_STAT, 32'h00000000);
    repeat (60) @(posedge mclk);
    bus_cycle(1'b0, `PPA_OFF_INT_STAT, 32'h0);
    `CHK(rd[1], 1'b1)
    bus_cycle(1'b1, `PPA_OFF_PRIORITY, 32'h00000000);
    bus_cycle(1'b1, `PPA_OFF_HOST_SRV, {30'h0, `PPA_HSR_INIT});
    bus_cycle(1'b1, `PPA_OFF_INT_STAT, 32'h00000000);
    repeat (100) @(posedge mclk);
    bus_cycle(1'b0, `PPA_OFF_INT_STAT, 32'h0);
    `CHK(rd[0], 1'b0)
    stop_test;
  end
endmodule

// [verilog/ppa_channel.sv]
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/100ps
`include "ppa_map.svh"
module ppa_channel #(
  parameter int CHANNELS = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] timer_counter_one,
  input wire logic [15:0] timer_counter_two,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic irq,
  output logic [CHANNELS-1:0] link_out
);
  import ppa_pkg::*;

  if (CHANNELS < 8 || CHANNELS > 16) begin : g_check
    $error("CHANNELS must lie between 8 and 16");
  end

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic [15:0] func_sel;
    logic [1:0] prio;
    logic [1:0] hsq;
    logic [1:0] hsr;
    logic int_en;
    logic [1:0] int_stat;
    logic [3:0] time_base_select_field;
    logic [2:0] pin_action_field;
    logic [1:0] pin_force_field;
    logic [7:0] max_count;
    logic [3:0] link_start;
    logic [3:0] link_count;
    logic [15:0] match_value;
    logic [23:0] last_accum;
    logic [23:0] accum;
    logic [7:0] count;
    logic [15:0] ref_cap;
    ppa_phase_type phase;
    logic pin_prev;
    logic irq;
    logic [CHANNELS-1:0] links;
    logic pin_oe;
  } ppa_state_type;

  ppa_state_type st;
  ppa_state_type next_st;

  // ****************************************
  // Helpers
  // ****************************************
  // Returns {capture on counter two, match on counter two}
  function automatic logic [1:0] base_decode(input logic [3:0] time_base_select_field);
    case (time_base_select_field)
      4'h0: base_decode = 2'h0;
      4'h1: base_decode = 2'h1;
      4'h2: base_decode = 2'h2;
      4'h3: base_decode = 2'h3;
      4'h4: base_decode = 2'h0;
      4'h5: base_decode = 2'h3;
      4'h6: base_decode = 2'h2;
      4'h7: base_decode = 2'h3;
      default: base_decode = 2'h0;
    endcase
  endfunction

  function automatic logic [CHANNELS-1:0] link_mask(input logic [3:0] start,
                                                    input logic [3:0] count);
    int i;
    link_mask = '0;
    for (i = 0; i < CHANNELS; i++) begin
      // Count is trusted as given
      if (i >= int'(start) && i < int'(start) + int'(count)) begin
        link_mask[i] = 1'b1;
      end
    end
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  // ****************************************
  // Input edge and measurement
  // ****************************************
  logic pin_sync;
  logic rise;
  logic fall;
  logic in_mode;
  logic out_mode;
  logic [1:0] base_sel;
  logic [15:0] capture;
  logic [15:0] meas;
  logic [23:0] sum;
  logic [7:0] new_count;
  logic enabled;
  logic init_req;
  logic meas_now;
  logic complete;
  logic match;
  logic detect;
  logic wr;
  logic [1:0] be_lo;
  logic [15:0] wd_lo;

  ppa_sync u_sync (
    .mclk(mclk),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  assign rise = pin_sync && !st.pin_prev;
  assign fall = !pin_sync && st.pin_prev;
  assign in_mode = st.time_base_select_field[3:2] == 2'h0;
  assign out_mode = st.time_base_select_field[3:2] == 2'h1;
  assign base_sel = base_decode(st.time_base_select_field);
  assign capture = base_sel[1] ? timer_counter_two : timer_counter_one;
  assign meas = 16'(capture - st.ref_cap);
  // Short mode wraps at 16 bits
  assign sum = st.hsq[0] ? {8'h00, 16'(st.accum[15:0] + meas)}
                         : 24'(st.accum + {8'h00, meas});
  assign new_count = 8'(st.count + 8'h01);
  // Any nonzero priority enables the channel; accumulating also needs input mode, the run phase and no pending init request
  assign enabled = st.prio != 2'h0;
  assign init_req = enabled && st.hsr == `PPA_HSR_INIT;
  assign meas_now = enabled && !init_req && in_mode && st.phase == PPA_RUN &&
                    (st.hsq[1] ? fall : rise);
  assign complete = meas_now && new_count >= st.max_count;
  assign match = out_mode && enabled &&
                 (base_sel[0] ? timer_counter_two : timer_counter_one) == st.match_value;
  always_comb begin
    case (ppa_pac_type'(st.pin_action_field))
      PPA_ACT_RISE: detect = rise;
      PPA_ACT_FALL: detect = fall;
      PPA_ACT_BOTH: detect = rise || fall;
      default: detect = 1'b0;
    endcase
  end
  assign wr = avs_write && !st.waitrequest;
  assign be_lo = avs_byteenable[1:0];
  assign wd_lo = avs_writedata[15:0];

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.pin_prev = pin_sync;
    next_st.links = '0;
    next_st.waitrequest = !((avs_read || avs_write) && st.waitrequest);
    if (avs_read && st.waitrequest) begin
      case (avs_address)
        `PPA_OFF_FUNC_SEL: next_st.readdata = {16'h0000, st.func_sel};
        `PPA_OFF_PRIORITY: next_st.readdata = {30'h00000000, st.prio};
        `PPA_OFF_HOST_SEQ: next_st.readdata = {30'h00000000, st.hsq};
        `PPA_OFF_HOST_SRV: next_st.readdata = {30'h00000000, st.hsr};
        `PPA_OFF_INT_EN: next_st.readdata = {31'h00000000, st.int_en};
        `PPA_OFF_INT_STAT: next_st.readdata = {30'h00000000, st.int_stat};
        `PPA_OFF_CHAN_CTL: next_st.readdata = {23'h000000, st.time_base_select_field, st.pin_action_field, st.pin_force_field};
        `PPA_OFF_MAX_COUNT: next_st.readdata = {24'h000000, st.max_count};
        `PPA_OFF_LINK_CFG: next_st.readdata = {24'h000000, st.link_count, st.link_start};
        `PPA_OFF_LAST_ACCUM: next_st.readdata = {8'h00, st.last_accum};
        `PPA_OFF_PERIOD_COUNT: next_st.readdata = {24'h000000, st.count};
        `PPA_OFF_RUN_ACCUM: next_st.readdata = {8'h00, st.accum};
        `PPA_OFF_MATCH_VALUE: next_st.readdata = {16'h0000, st.match_value};
        default: next_st.readdata = 32'h00000000;
      endcase
    end
    // Service request clears itself; a fresh write below wins
    if (init_req) begin
      next_st.hsr = 2'h0;
    end
    if (wr) begin
      case (avs_address)
        `PPA_OFF_FUNC_SEL: next_st.func_sel = merge16(st.func_sel, wd_lo, be_lo);
        `PPA_OFF_PRIORITY: if (be_lo[0]) next_st.prio = wd_lo[1:0];
        `PPA_OFF_HOST_SEQ: if (be_lo[0]) next_st.hsq = wd_lo[1:0];
        `PPA_OFF_HOST_SRV: if (be_lo[0]) next_st.hsr = wd_lo[1:0];
        `PPA_OFF_INT_EN: if (be_lo[0]) next_st.int_en = wd_lo[0];
        // Writing zero clears a status bit
        `PPA_OFF_INT_STAT: if (be_lo[0]) next_st.int_stat = st.int_stat & wd_lo[1:0];
        `PPA_OFF_CHAN_CTL: begin
          if (be_lo[0]) begin
            next_st.pin_force_field = wd_lo[`PPA_CTL_PSC_LSB +: 2];
          end
          if (be_lo[0] && !wd_lo[`PPA_CTL_PAC_LSB + 2]) begin
            next_st.pin_action_field = wd_lo[`PPA_CTL_PAC_LSB +: 3];
          end
          if (be_lo == 2'h3 && !wd_lo[`PPA_CTL_TBS_LSB + 3]) begin
            next_st.time_base_select_field = wd_lo[`PPA_CTL_TBS_LSB +: 4];
          end
        end
        `PPA_OFF_MAX_COUNT: begin
          if (be_lo[0]) begin
            next_st.max_count = wd_lo[7:0];
            if (wd_lo[7:0] <= st.count) begin
              next_st.accum = 24'h000000;
              next_st.count = 8'h00;
            end
          end
        end
        `PPA_OFF_LINK_CFG: begin
          if (be_lo[0]) begin
            next_st.link_start = wd_lo[3:0];
            next_st.link_count = wd_lo[`PPA_LINK_COUNT_LSB +: 4];
          end
        end
        `PPA_OFF_MATCH_VALUE: next_st.match_value = merge16(st.match_value, wd_lo, be_lo);
        default: next_st.readdata = next_st.readdata;
      endcase
    end
    // Hardware events follow the writes so a set beats a clear
    if (!enabled) begin
      next_st.phase = PPA_IDLE;
    end else if (init_req) begin
      next_st.accum = 24'h000000;
      next_st.count = 8'h00;
      next_st.phase = PPA_ARMED;
    end else begin
      case (st.phase)
        PPA_IDLE: next_st.phase = PPA_IDLE;
        PPA_ARMED: begin
          if (in_mode && rise) begin
            next_st.ref_cap = capture;
            next_st.phase = PPA_RUN;
          end
        end
        PPA_RUN: begin
          if (meas_now) begin
            next_st.ref_cap = capture;
            next_st.accum = sum;
            next_st.count = new_count;
            if (st.hsq[1]) begin
              next_st.phase = PPA_ARMED;
            end
          end
          if (complete) begin
            next_st.last_accum = sum;
            next_st.accum = 24'h000000;
            next_st.count = 8'h00;
            next_st.int_stat[`PPA_STAT_DONE_BIT] = 1'b1;
            if (st.hsq[0]) begin
              next_st.links = link_mask(st.link_start, st.link_count);
            end
          end
        end
        default: next_st.phase = PPA_IDLE;
      endcase
    end
    if (in_mode && detect) begin
      next_st.int_stat[`PPA_STAT_DETECT_BIT] = 1'b1;
    end
    next_st.irq = st.int_en && st.int_stat[`PPA_STAT_DONE_BIT];
    next_st.pin_oe = out_mode;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
      st.waitrequest <= 1'b1;
      st.func_sel <= `PPA_RST_FUNC_SEL;
      st.prio <= `PPA_RST_PRIORITY;
      st.hsq <= `PPA_RST_HOST_SEQ;
      st.hsr <= `PPA_RST_HOST_SRV;
      st.pin_force_field <= `PPA_RST_PSC;
      st.pin_action_field <= `PPA_RST_PAC;
      st.time_base_select_field <= `PPA_RST_TBS;
      st.max_count <= `PPA_RST_MAX_COUNT;
      st.link_start <= `PPA_RST_LINK_START;
      st.link_count <= `PPA_RST_LINK_COUNT;
      st.match_value <= `PPA_RST_MATCH_VALUE;
      st.phase <= PPA_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ppa_pin_drive u_pin (
    .mclk(mclk),
    .reset(reset),
    .match(match),
    .pin_action_field(st.pin_action_field),
    .pin_force_field(st.pin_force_field),
    .pin_out(pin_out)
  );

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  assign irq = st.irq;
  assign link_out = st.links;
  assign pin_oe = st.pin_oe;

  // ****************************************
  // Checks
  // ****************************************
  irq_gated_a: assert property (@(posedge mclk) disable iff (reset)
    !st.int_en |=> !irq) else $error("interrupt without enable");
  done_flag_a: assert property (@(posedge mclk) disable iff (reset)
    complete |=> st.int_stat[0] && st.count == 8'h00) else $error("completion lost");
  early_done_a: assert property (@(posedge mclk) disable iff (reset)
    meas_now && new_count < st.max_count |=> st.count == $past(new_count))
    else $error("early completion");
  last_hold_a: assert property (@(posedge mclk) disable iff (reset)
    !complete |=> $stable(st.last_accum)) else $error("last sum disturbed");
  link_mode_a: assert property (@(posedge mclk) disable iff (reset)
    link_out != '0 |-> $past(complete) && $past(st.hsq[0])) else $error("stray link");
  short_sum_a: assert property (@(posedge mclk) disable iff (reset)
    complete && st.hsq[0] |=> st.last_accum[23:16] == 8'h00) else $error("short sum wide");
  init_clear_a: assert property (@(posedge mclk) disable iff (reset)
    init_req |=> st.accum == 24'h000000 && st.count == 8'h00 && st.phase == PPA_ARMED)
    else $error("init did not clear");
  disabled_idle_a: assert property (@(posedge mclk) disable iff (reset)
    !enabled |=> st.phase == PPA_IDLE) else $error("disabled channel active");
  max_term_a: assert property (@(posedge mclk) disable iff (reset)
    wr && avs_address == `PPA_OFF_MAX_COUNT && be_lo[0] && !meas_now &&
    !init_req && wd_lo[7:0] <= st.count |=> st.count == 8'h00)
    else $error("max count did not terminate");
  pac_keep_a: assert property (@(posedge mclk) disable iff (reset)
    wr && avs_address == `PPA_OFF_CHAN_CTL && wd_lo[4] |=> st.pin_action_field == $past(st.pin_action_field))
    else $error("pin action changed");
  wait_answer_a: assert property (@(posedge mclk) disable iff (reset)
    (avs_read || avs_write) && st.waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing");
endmodule

// [verilog/ppa_map.svh]
`ifndef PPA_MAP_SVH
`define PPA_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PPA_OFF_FUNC_SEL 6'h00
`define PPA_OFF_PRIORITY 6'h04
`define PPA_OFF_HOST_SEQ 6'h08
`define PPA_OFF_HOST_SRV 6'h0C
`define PPA_OFF_INT_EN 6'h10
`define PPA_OFF_INT_STAT 6'h14
`define PPA_OFF_CHAN_CTL 6'h18
`define PPA_OFF_MAX_COUNT 6'h1C
`define PPA_OFF_LINK_CFG 6'h20
`define PPA_OFF_LAST_ACCUM 6'h24
`define PPA_OFF_PERIOD_COUNT 6'h28
`define PPA_OFF_RUN_ACCUM 6'h2C
`define PPA_OFF_MATCH_VALUE 6'h30

// ****************************************
// Field positions
// ****************************************
`define PPA_CTL_PSC_LSB 0
`define PPA_CTL_PAC_LSB 2
`define PPA_CTL_TBS_LSB 5
`define PPA_LINK_COUNT_LSB 4
`define PPA_STAT_DONE_BIT 0
`define PPA_STAT_DETECT_BIT 1
`define PPA_HSR_INIT 2'h2

// ****************************************
// Reset values
// ****************************************
`define PPA_RST_FUNC_SEL 16'h0000
`define PPA_RST_PRIORITY 2'h0
`define PPA_RST_HOST_SEQ 2'h0
`define PPA_RST_HOST_SRV 2'h0
`define PPA_RST_PSC 2'h3
`define PPA_RST_PAC 3'h0
`define PPA_RST_TBS 4'h0
`define PPA_RST_MAX_COUNT 8'h01
`define PPA_RST_LINK_START 4'h0
`define PPA_RST_LINK_COUNT 4'h1
`define PPA_RST_MATCH_VALUE 16'h0000

`endif

// [verilog/ppa_pin_drive.sv]
`timescale 1ns/100ps
module ppa_pin_drive (
  input wire logic mclk,
  input wire logic reset,
  input wire logic match,
  input wire logic [2:0] pin_action_field,
  input wire logic [1:0] pin_force_field,
  output logic pin_out
);
  import ppa_pkg::*;

  typedef struct packed {
    logic latch;
    logic out;
  } ppa_drive_type;

  ppa_drive_type st;
  ppa_drive_type next_st;

  always_comb begin
    next_st = st;
    if (match) begin
      case (ppa_pac_type'(pin_action_field))
        PPA_ACT_RISE: next_st.latch = 1'b1;
        PPA_ACT_FALL: next_st.latch = 1'b0;
        PPA_ACT_BOTH: next_st.latch = ~st.latch;
        default: next_st.latch = st.latch;
      endcase
    end
    // Force acts on the pin only, never on the latch
    case (ppa_psc_type'(pin_force_field))
      PPA_FORCE_LATCH: next_st.out = next_st.latch;
      PPA_FORCE_HIGH: next_st.out = 1'b1;
      PPA_FORCE_LOW: next_st.out = 1'b0;
      default: next_st.out = st.out;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.out;

  force_high_a: assert property (@(posedge mclk) disable iff (reset)
    pin_force_field == 2'h1 |=> pin_out) else $error("force high not driven");
  latch_kept_a: assert property (@(posedge mclk) disable iff (reset)
    !match |=> $stable(st.latch)) else $error("latch moved without match");
  toggle_match_a: assert property (@(posedge mclk) disable iff (reset)
    match && pin_action_field == 3'h3 |=> st.latch != $past(st.latch)) else $error("toggle missed");
endmodule

// [verilog/ppa_pkg.sv]
package ppa_pkg;
  typedef enum logic [1:0] {
    PPA_IDLE = 2'h0,
    PPA_ARMED = 2'h1,
    PPA_RUN = 2'h3
  } ppa_phase_type;

  typedef enum logic [1:0] {
    PPA_FORCE_LATCH = 2'h0,
    PPA_FORCE_HIGH = 2'h1,
    PPA_FORCE_LOW = 2'h2,
    PPA_FORCE_NONE = 2'h3
  } ppa_psc_type;

  typedef enum logic [2:0] {
    PPA_ACT_NONE = 3'h0,
    PPA_ACT_RISE = 3'h1,
    PPA_ACT_FALL = 3'h2,
    PPA_ACT_BOTH = 3'h3
  } ppa_pac_type;
endpackage

// [verilog/ppa_sync.sv]
`timescale 1ns/100ps
module ppa_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  import ppa_pkg::*;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } ppa_sync_type;

  ppa_sync_type st;
  ppa_sync_type next_st;

  always_comb begin
    next_st = st;
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;
endmodule
